// file: common/dssb_map.vh
`ifndef DSSB_MAP_VH
`define DSSB_MAP_VH

// --------------------------------
// register offsets (byte addresses)
// --------------------------------
`define DSSB_REG_REF_FREQ     8'h00
`define DSSB_REG_START_FREQ   8'h04
`define DSSB_REG_START_HOLD   8'h08
`define DSSB_REG_STOP_FREQ    8'h0C
`define DSSB_REG_STOP_HOLD    8'h10
`define DSSB_REG_BRK_FREQ     8'h14
`define DSSB_REG_BRK_LEVEL    8'h18
`define DSSB_REG_BRK_TIME     8'h1C
`define DSSB_REG_BRK_RESP     8'h20
`define DSSB_REG_CARRIER      8'h24
`define DSSB_REG_TONE         8'h28
`define DSSB_REG_CAR_RED      8'h2C
`define DSSB_REG_MON_FORM     8'h30
`define DSSB_REG_MON_GAIN     8'h34
`define DSSB_REG_MON_ITEM     8'h38
`define DSSB_REG_MON_RATE     8'h3C
`define DSSB_REG_RAMP_STEP    8'h40
`define DSSB_REG_STATUS       8'h44
`define DSSB_REG_OUT_FREQ     8'h48

// --------------------------------
// reset values
// --------------------------------
`define DSSB_RST_START_FREQ   16'h0032
`define DSSB_RST_STOP_FREQ    16'h0032
`define DSSB_RST_BRK_FREQ     16'h0000
`define DSSB_RST_CARRIER      6'h08
`define DSSB_RST_MON_GAIN     9'h064
`define DSSB_RST_MON_RATE     13'h05DC
`define DSSB_RST_RAMP_STEP    16'h0001

// --------------------------------
// encodings and limits
// --------------------------------
`define DSSB_FORM_VOLTAGE     2'h0
`define DSSB_FORM_PULSE       2'h2
`define DSSB_BRK_LEVEL_MAX    7'h64
`define DSSB_CAR_MIN          6'h03
`define DSSB_CAR_MAX          6'h3C
`define DSSB_CAR_TONE_MAX     6'h1C
`define DSSB_CAR_MODULUS      17'h09C40
`define DSSB_MON_GAIN_MAX     9'h12C
`define DSSB_MON_RATE_MAX     13'h1770
`define DSSB_PWM_TOP          19'h63F9B
`define DSSB_PULSE_MODULUS    36'h988CF6980
`define DSSB_MON_FULL         12'hFFF

// --------------------------------
// timing
// --------------------------------
`define DSSB_CLK_NS           50
`define DSSB_TICK_NS          1000000
`define DSSB_TICK_CYCLES      (`DSSB_TICK_NS / `DSSB_CLK_NS)

`endif

// file: hw/dssb_carrier.v
`timescale 1ns/1ps
`include "dssb_map.vh"

module dssb_carrier (
    input  wire       clk_sys_i,
    input  wire       reset_i,
    input  wire [5:0] carrier_sel_i,
    input  wire       hot_i,
    input  wire       reduce_off_i,
    input  wire [3:0] tone_i,
    output reg        carrier_o,
    output reg  [5:0] carrier_eff_o,
    output reg  [3:0] tone_o
);

    reg  [5:0]  sel_c;
    reg  [5:0]  eff_c;
    reg  [16:0] acc_q;
    wire [16:0] acc_sum = acc_q + {11'h000, carrier_eff_o};

    // --------------------------------
    // selection clamp, thermal reduction, tone gate
    // --------------------------------
    always @* begin
        sel_c = carrier_sel_i;
        if (sel_c < `DSSB_CAR_MIN) begin
            sel_c = `DSSB_CAR_MIN;
        end
        if (sel_c > `DSSB_CAR_MAX) begin
            sel_c = `DSSB_CAR_MAX;
        end
        eff_c = sel_c;
        if (hot_i && !reduce_off_i) begin
            eff_c = {1'b0, sel_c[5:1]};
            if (eff_c < `DSSB_CAR_MIN) begin
                eff_c = `DSSB_CAR_MIN;
            end
        end
    end

    // --------------------------------
    // modulo accumulator: toggle rate = eff * 250 Hz * 2
    // --------------------------------
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            acc_q         <= 17'h00000;
            carrier_o     <= 1'b0;
            carrier_eff_o <= `DSSB_RST_CARRIER;
            tone_o        <= 4'h0;
        end else begin
            carrier_eff_o <= eff_c;
            tone_o        <= (eff_c <= `DSSB_CAR_TONE_MAX) ? tone_i : 4'h0;
            if (acc_sum >= `DSSB_CAR_MODULUS) begin
                acc_q     <= acc_sum - `DSSB_CAR_MODULUS;
                carrier_o <= ~carrier_o;
            end else begin
                acc_q     <= acc_sum;
            end
        end
    end

endmodule

// file: hw/dssb_monitor.v
`timescale 1ns/1ps
`include "dssb_map.vh"

module dssb_monitor (
    input  wire        clk_sys_i,
    input  wire        reset_i,
    input  wire [11:0] value_i,
    input  wire [1:0]  form_i,
    input  wire [8:0]  gain_i,
    input  wire [12:0] rate_i,
    output reg         mon_pwm_o,
    output reg         mon_pulse_o
);

    reg  [18:0] pwm_cnt_q;
    reg  [35:0] pls_acc_q;
    wire [8:0]  gain_c  = (gain_i > `DSSB_MON_GAIN_MAX) ? `DSSB_MON_GAIN_MAX : gain_i;
    wire [12:0] rate_c  = (rate_i > `DSSB_MON_RATE_MAX) ? `DSSB_MON_RATE_MAX : rate_i;
    wire [20:0] duty_c  = value_i * gain_c;
    wire [24:0] step_c  = value_i * rate_c;
    wire [35:0] pls_sum = pls_acc_q + {11'h000, step_c};

    // --------------------------------
    // voltage form: pwm duty = value * gain / (full * 100)
    // pulse form: toggle at value/full * rate * 2, 50 % duty
    // --------------------------------
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            pwm_cnt_q   <= 19'h00000;
            pls_acc_q   <= 36'h000000000;
            mon_pwm_o   <= 1'b0;
            mon_pulse_o <= 1'b0;
        end else begin
            pwm_cnt_q <= (pwm_cnt_q == `DSSB_PWM_TOP) ? 19'h00000 : pwm_cnt_q + 19'h00001;
            mon_pwm_o <= (form_i == `DSSB_FORM_VOLTAGE) &&
                         ({2'b00, pwm_cnt_q} < duty_c);
            if (form_i != `DSSB_FORM_PULSE) begin
                pls_acc_q   <= 36'h000000000;
                mon_pulse_o <= 1'b0;
            end else if (pls_sum >= `DSSB_PULSE_MODULUS) begin
                pls_acc_q   <= pls_sum - `DSSB_PULSE_MODULUS;
                mon_pulse_o <= ~mon_pulse_o;
            end else begin
                pls_acc_q   <= pls_sum;
            end
        end
    end

endmodule

// file: hw/dssb_top.v
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "dssb_map.vh"

// Notes on behaviour
// - brake at braking start freq while stopping
// - stop on run low or reference below stop
// - zero braking time disables timed braking
// - brake level is percent of rated current
// - response select: slow or quick current rise
// - brake input held keeps braking active
// - brake input while stopped also brakes
// - output begins at starting frequency
// - output ceases at stop frequency
// - hold starting frequency for start hold
// - hold stop frequency for stop hold
// - start below stop: wait reference above stop
// - carrier selectable 0.75 to 15 kHz
// - hot drive lowers carrier unless disabled
// - tone effective only at carrier <= 7 kHz
// - monitor form: 0 voltage, 2 pulse train
// - pulse form near 50 percent duty
// - voltage gain 0 to 300 percent
// - pulse rate means count at 100 percent
module dssb_top #(
    parameter TICK_CYCLES = `DSSB_TICK_CYCLES
) (
    input  wire        clk_sys_i,
    input  wire        reset_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [31:0] reg_rdata_o,
    input  wire        run_cmd_i,
    input  wire        brake_enable_input_i,
    input  wire        drive_hot_i,
    output reg  [15:0] out_freq_o,
    output reg         out_drive_o,
    output reg         dc_brake_o,
    output reg  [6:0]  brake_current_o,
    output reg         carrier_o,
    output reg  [3:0]  tone_o,
    output reg         mon_pwm_o,
    output reg         mon_pulse_o
);

    // --------------------------------
    // states
    // --------------------------------
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_START = 3'h1;
    localparam [2:0] ST_RUN   = 3'h2;
    localparam [2:0] ST_STOP  = 3'h3;
    localparam [2:0] ST_BRAKE = 3'h4;

    // --------------------------------
    // configuration registers
    // --------------------------------
    reg [15:0] ref_freq_q;
    reg [15:0] start_freq_q;
    reg [15:0] start_hold_time_q;
    reg [15:0] stop_freq_q;
    reg [15:0] stop_hold_time_q;
    reg [15:0] braking_start_freq_q;
    reg [6:0]  braking_current_level_q;
    reg [15:0] braking_duration_q;
    reg        braking_response_select_q;
    reg [5:0]  carrier_freq_select_q;
    reg [3:0]  motor_tone_level_q;
    reg        carrier_reduction_control_q;
    reg [1:0]  monitor_output_form_q;
    reg [8:0]  monitor_voltage_gain_q;
    reg [1:0]  monitor_item_select_q;
    reg [12:0] monitor_pulse_rate_q;
    reg [15:0] ramp_step_q;

    // --------------------------------
    // pin synchronisers
    // --------------------------------
    reg [1:0] run_sync_q;
    reg [1:0] brk_sync_q;
    reg [1:0] hot_sync_q;
    wire      run_s = run_sync_q[1];
    wire      brk_s = brk_sync_q[1];

    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            run_sync_q <= 2'b00;
            brk_sync_q <= 2'b00;
            hot_sync_q <= 2'b00;
        end else begin
            run_sync_q <= {run_sync_q[0], run_cmd_i};
            brk_sync_q <= {brk_sync_q[0], brake_enable_input_i};
            hot_sync_q <= {hot_sync_q[0], drive_hot_i};
        end
    end

    // --------------------------------
    // time base
    // --------------------------------
    reg  [31:0] tick_cnt_q;
    reg         tick_q;

    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            tick_cnt_q <= 32'h00000000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == TICK_CYCLES - 1) begin
            tick_cnt_q <= 32'h00000000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
            tick_q     <= 1'b0;
        end
    end

    // --------------------------------
    // sequencer
    // --------------------------------
    reg  [2:0]  state_q;
    reg  [15:0] freq_q;
    reg  [15:0] timer_q;
    reg  [6:0]  cur_q;
    wire        stopping   = !run_s || (ref_freq_q < stop_freq_q);
    wire        brk_timed  = (braking_duration_q != 16'h0000);
    wire        start_ok   = run_s && (ref_freq_q > stop_freq_q ||
                             (ref_freq_q == stop_freq_q && start_freq_q >= stop_freq_q));
    wire [6:0]  lvl_c      = (braking_current_level_q > `DSSB_BRK_LEVEL_MAX) ?
                             `DSSB_BRK_LEVEL_MAX : braking_current_level_q;
    wire [16:0] freq_up    = {1'b0, freq_q} + {1'b0, ramp_step_q};
    wire        timer_done = (timer_q == 16'h0000);

    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
            freq_q  <= 16'h0000;
            timer_q <= 16'h0000;
            cur_q   <= 7'h00;
        end else begin
            if (tick_q && !timer_done) begin
                timer_q <= timer_q - 16'h0001;
            end
            case (state_q)
            ST_IDLE: begin
                freq_q <= 16'h0000;
                cur_q  <= 7'h00;
                if (brk_s) begin
                    state_q <= ST_BRAKE;
                    timer_q <= 16'h0000;
                end else if (start_ok) begin
                    state_q <= ST_START;
                    freq_q  <= start_freq_q;
                    timer_q <= start_hold_time_q;
                end
            end
            ST_START: begin
                if (stopping) begin
                    state_q <= ST_RUN;
                end else if (timer_done) begin
                    state_q <= ST_RUN;
                end
            end
            ST_RUN: begin
                if (freq_q <= stop_freq_q && stopping) begin
                    state_q <= ST_STOP;
                    freq_q  <= stop_freq_q;
                    timer_q <= stop_hold_time_q;
                end else if (stopping && brk_timed && freq_q <= braking_start_freq_q) begin
                    state_q <= ST_BRAKE;
                    freq_q  <= 16'h0000;
                    timer_q <= braking_duration_q;
                end else if (tick_q) begin
                    if (stopping) begin
                        freq_q <= (freq_q > ramp_step_q) ? freq_q - ramp_step_q : 16'h0000;
                    end else if (freq_q < ref_freq_q) begin
                        freq_q <= (freq_up[15:0] > ref_freq_q || freq_up[16]) ? ref_freq_q : freq_up[15:0];
                    end else if (freq_q > ref_freq_q) begin
                        freq_q <= (freq_q - ramp_step_q < ref_freq_q || freq_q < ramp_step_q) ?
                                  ref_freq_q : freq_q - ramp_step_q;
                    end
                end
            end
            ST_STOP: begin
                if (timer_done) begin
                    freq_q <= 16'h0000;
                    if (brk_s || (brk_timed && stop_freq_q <= braking_start_freq_q)) begin
                        state_q <= ST_BRAKE;
                        timer_q <= braking_duration_q;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
            end
            ST_BRAKE: begin
                freq_q <= 16'h0000;
                if (braking_response_select_q) begin
                    cur_q <= lvl_c;
                end else if (tick_q && cur_q < lvl_c) begin
                    cur_q <= cur_q + 7'h01;
                end else if (cur_q > lvl_c) begin
                    cur_q <= lvl_c;
                end
                if (timer_done && !brk_s) begin
                    state_q <= ST_IDLE;
                    cur_q   <= 7'h00;
                end
            end
            default: begin
                state_q <= ST_IDLE;
            end
            endcase
        end
    end

    // --------------------------------
    // output stage
    // --------------------------------
    wire       car_w;
    wire [5:0] car_eff_w;
    wire [3:0] tone_w;
    wire       pwm_w;
    wire       pulse_w;
    reg [11:0] mon_val_c;

    always @* begin
        case (monitor_item_select_q)
        2'h0:    mon_val_c = freq_q[15:4];
        2'h1:    mon_val_c = {cur_q, 5'h00};
        default: mon_val_c = `DSSB_MON_FULL;
        endcase
    end

    dssb_carrier u_carrier (
        .clk_sys_i     (clk_sys_i),
        .reset_i       (reset_i),
        .carrier_sel_i (carrier_freq_select_q),
        .hot_i         (hot_sync_q[1]),
        .reduce_off_i  (carrier_reduction_control_q),
        .tone_i        (motor_tone_level_q),
        .carrier_o     (car_w),
        .carrier_eff_o (car_eff_w),
        .tone_o        (tone_w)
    );

    dssb_monitor u_monitor (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .value_i     (mon_val_c),
        .form_i      (monitor_output_form_q),
        .gain_i      (monitor_voltage_gain_q),
        .rate_i      (monitor_pulse_rate_q),
        .mon_pwm_o   (pwm_w),
        .mon_pulse_o (pulse_w)
    );

    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            out_freq_o      <= 16'h0000;
            out_drive_o     <= 1'b0;
            dc_brake_o      <= 1'b0;
            brake_current_o <= 7'h00;
            carrier_o       <= 1'b0;
            tone_o          <= 4'h0;
            mon_pwm_o       <= 1'b0;
            mon_pulse_o     <= 1'b0;
        end else begin
            out_freq_o      <= freq_q;
            out_drive_o     <= (state_q == ST_START) || (state_q == ST_RUN) || (state_q == ST_STOP);
            dc_brake_o      <= (state_q == ST_BRAKE);
            brake_current_o <= cur_q;
            carrier_o       <= car_w;
            tone_o          <= tone_w;
            mon_pwm_o       <= pwm_w;
            mon_pulse_o     <= pulse_w;
        end
    end

    // --------------------------------
    // register bus
    // --------------------------------
    always @(posedge clk_sys_i) begin
        if (reset_i) begin
            ref_freq_q                  <= 16'h0000;
            start_freq_q                <= `DSSB_RST_START_FREQ;
            start_hold_time_q           <= 16'h0000;
            stop_freq_q                 <= `DSSB_RST_STOP_FREQ;
            stop_hold_time_q            <= 16'h0000;
            braking_start_freq_q        <= `DSSB_RST_BRK_FREQ;
            braking_current_level_q     <= 7'h00;
            braking_duration_q          <= 16'h0000;
            braking_response_select_q   <= 1'b0;
            carrier_freq_select_q       <= `DSSB_RST_CARRIER;
            motor_tone_level_q          <= 4'h0;
            carrier_reduction_control_q <= 1'b0;
            monitor_output_form_q       <= `DSSB_FORM_VOLTAGE;
            monitor_voltage_gain_q      <= `DSSB_RST_MON_GAIN;
            monitor_item_select_q       <= 2'h0;
            monitor_pulse_rate_q        <= `DSSB_RST_MON_RATE;
            ramp_step_q                 <= `DSSB_RST_RAMP_STEP;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
            `DSSB_REG_REF_FREQ:   ref_freq_q                  <= reg_wdata_i[15:0];
            `DSSB_REG_START_FREQ: start_freq_q                <= reg_wdata_i[15:0];
            `DSSB_REG_START_HOLD: start_hold_time_q           <= reg_wdata_i[15:0];
            `DSSB_REG_STOP_FREQ:  stop_freq_q                 <= reg_wdata_i[15:0];
            `DSSB_REG_STOP_HOLD:  stop_hold_time_q            <= reg_wdata_i[15:0];
            `DSSB_REG_BRK_FREQ:   braking_start_freq_q        <= reg_wdata_i[15:0];
            `DSSB_REG_BRK_LEVEL:  braking_current_level_q     <= reg_wdata_i[6:0];
            `DSSB_REG_BRK_TIME:   braking_duration_q          <= reg_wdata_i[15:0];
            `DSSB_REG_BRK_RESP:   braking_response_select_q   <= reg_wdata_i[0];
            `DSSB_REG_CARRIER:    carrier_freq_select_q       <= reg_wdata_i[5:0];
            `DSSB_REG_TONE:       motor_tone_level_q          <= reg_wdata_i[3:0];
            `DSSB_REG_CAR_RED:    carrier_reduction_control_q <= reg_wdata_i[0];
            `DSSB_REG_MON_FORM:   monitor_output_form_q       <= reg_wdata_i[1:0];
            `DSSB_REG_MON_GAIN:   monitor_voltage_gain_q      <= reg_wdata_i[8:0];
            `DSSB_REG_MON_ITEM:   monitor_item_select_q       <= reg_wdata_i[1:0];
            `DSSB_REG_MON_RATE:   monitor_pulse_rate_q        <= reg_wdata_i[12:0];
            `DSSB_REG_RAMP_STEP:  ramp_step_q                 <= reg_wdata_i[15:0];
            default: begin
            end
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk_sys_i) begin
        if (reset_i || !reg_rd_i) begin
            reg_rdata_o <= 32'h00000000;
        end else begin
            case (reg_addr_i)
            `DSSB_REG_REF_FREQ:   reg_rdata_o <= {16'h0000, ref_freq_q};
            `DSSB_REG_START_FREQ: reg_rdata_o <= {16'h0000, start_freq_q};
            `DSSB_REG_START_HOLD: reg_rdata_o <= {16'h0000, start_hold_time_q};
            `DSSB_REG_STOP_FREQ:  reg_rdata_o <= {16'h0000, stop_freq_q};
            `DSSB_REG_STOP_HOLD:  reg_rdata_o <= {16'h0000, stop_hold_time_q};
            `DSSB_REG_BRK_FREQ:   reg_rdata_o <= {16'h0000, braking_start_freq_q};
            `DSSB_REG_BRK_LEVEL:  reg_rdata_o <= {25'h0000000, braking_current_level_q};
            `DSSB_REG_BRK_TIME:   reg_rdata_o <= {16'h0000, braking_duration_q};
            `DSSB_REG_BRK_RESP:   reg_rdata_o <= {31'h00000000, braking_response_select_q};
            `DSSB_REG_CARRIER:    reg_rdata_o <= {26'h0000000, carrier_freq_select_q};
            `DSSB_REG_TONE:       reg_rdata_o <= {28'h0000000, motor_tone_level_q};
            `DSSB_REG_CAR_RED:    reg_rdata_o <= {31'h00000000, carrier_reduction_control_q};
            `DSSB_REG_MON_FORM:   reg_rdata_o <= {30'h00000000, monitor_output_form_q};
            `DSSB_REG_MON_GAIN:   reg_rdata_o <= {23'h000000, monitor_voltage_gain_q};
            `DSSB_REG_MON_ITEM:   reg_rdata_o <= {30'h00000000, monitor_item_select_q};
            `DSSB_REG_MON_RATE:   reg_rdata_o <= {19'h00000, monitor_pulse_rate_q};
            `DSSB_REG_RAMP_STEP:  reg_rdata_o <= {16'h0000, ramp_step_q};
            `DSSB_REG_STATUS:     reg_rdata_o <= {9'h000, car_eff_w, cur_q, 4'h0,
                                                  hot_sync_q[1], brk_s, run_s, state_q};
            `DSSB_REG_OUT_FREQ:   reg_rdata_o <= {16'h0000, freq_q};
            default:              reg_rdata_o <= 32'h00000000;
            endcase
        end
    end

endmodule

// file: test/dssb_pins.sv
`timescale 1ns/1ps
module dssb_pins (
    input  wire       clk_sys_i,
    input  wire [2:0] req_i,
    output reg  [2:0] pin_o
);
    initial pin_o = 3'h0;
    always @(posedge clk_sys_i) begin
        pin_o <= req_i;
    end
endmodule

// file: test/dssb_checker.sv
`timescale 1ns/1ps
module dssb_checker (
    input wire        clk_sys_i,
    input wire        reset_i,
    input wire        reg_rd_i,
    input wire [31:0] reg_rdata_o,
    input wire        brake_enable_input_i,
    input wire        out_drive_o,
    input wire        dc_brake_o,
    input wire [6:0]  brake_current_o,
    input wire        mon_pwm_o,
    input wire        mon_pulse_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    chk_brake_level: assert property (dc_brake_o |-> brake_current_o <= 7'h64)
        else $error("brake current above rated");
    chk_brake_nodrive: assert property (dc_brake_o |-> !out_drive_o)
        else $error("drive active while braking");
    chk_mon_form: assert property (!(mon_pwm_o && mon_pulse_o))
        else $error("both monitor forms active");
    chk_input_brake: assert property ((brake_enable_input_i && !out_drive_o) [*5] |=> dc_brake_o)
        else $error("brake input while stopped did not brake");
    chk_input_hold: assert property (brake_enable_input_i [*4] ##0 dc_brake_o |=> dc_brake_o)
        else $error("braking ended while brake input high");
    chk_current_rise: assert property (dc_brake_o && $past(dc_brake_o) |->
        brake_current_o >= $past(brake_current_o))
        else $error("brake current fell during braking");
    chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside read cycle");
    chk_rdata_one: assert property (reg_rd_i ##1 !reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data stood too long");
endmodule

bind dssb_top dssb_checker chk_u (.clk_sys_i, .reset_i, .reg_rd_i, .reg_rdata_o, .brake_enable_input_i,
    .out_drive_o, .dc_brake_o, .brake_current_o, .mon_pwm_o, .mon_pulse_o);

// file: test/dssb_top_tb.sv
`timescale 1ns/1ps
`include "dssb_map.vh"
module dssb_top_tb;
    reg         clk_sys_i = 1'b0;
    reg         reset_i = 1'b1;
    reg  [7:0]  reg_addr_i = 8'h00;
    reg  [31:0] reg_wdata_i = 32'h0;
    reg         reg_wr_i = 1'b0;
    reg         reg_rd_i = 1'b0;
    reg  [2:0]  req = 3'h0;
    wire [2:0]  pin;
    wire [31:0] reg_rdata_o;
    wire [15:0] out_freq_o;
    wire [6:0]  brake_current_o;
    wire [3:0]  tone_o;
    wire        out_drive_o, dc_brake_o, carrier_o, mon_pwm_o, mon_pulse_o;
    integer     num_errors = 0;
    integer     num_checks = 0;
    integer     n, a, b;
    initial forever #25 clk_sys_i = ~clk_sys_i;
    dssb_pins pins_u (.clk_sys_i, .req_i(req), .pin_o(pin));
    dssb_top #(.TICK_CYCLES(20)) dut_u (.clk_sys_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .run_cmd_i(pin[0]), .brake_enable_input_i(pin[1]), .drive_hot_i(pin[2]), .out_freq_o,
        .out_drive_o, .dc_brake_o, .brake_current_o, .carrier_o, .tone_o, .mon_pwm_o, .mon_pulse_o);
    task give_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("unexpected %0s exp %h got %h", nm, e, g);
            num_errors++;
        end
    endtask
    task wr(input [7:0] ad, input [31:0] d);
        reg_addr_i <= ad;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    // read data stands only in the cycle after the strobe edge
    task rc(input string nm, input [7:0] ad, input [31:0] e);
        reg_addr_i <= ad;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk(nm, e, reg_rdata_o);
    endtask
    function pick(input integer w);
        case (w)
            0: pick = out_drive_o;
            1: pick = dc_brake_o;
            2: pick = carrier_o;
            3: pick = mon_pulse_o;
            4: pick = (out_freq_o === 16'h0040);
            default: pick = mon_pwm_o;
        endcase
    endfunction
    task wt(input integer w, input v, input integer mx, output integer c);
        c = 0;
        while (pick(w) !== v && c < mx) begin
            @(posedge clk_sys_i);
            #1 c++;
        end
        if (pick(w) !== v) begin
            $display("unexpected timeout on %0d", w);
            num_errors++;
            give_verdict;
        end
    endtask
    task hold(input integer w, input v, input integer cy, input string nm);
        integer i, bad;
        bad = 0;
        for (i = 0; i < cy; i++) begin
            @(posedge clk_sys_i);
            #1 bad = bad | (pick(w) !== v);
        end
        chk(nm, 0, bad);
    endtask
    // settle a rate change, wait for the next rising edge, then measure both halves
    task per(input integer w, output integer h0, output integer h1);
        repeat (8) @(posedge clk_sys_i);
        wt(w, 0, 6000, h0);
        wt(w, 1, 6000, h0);
        wt(w, 0, 6000, h0);
        wt(w, 1, 6000, h1);
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        rc("carrier rst", `DSSB_REG_CARRIER, 32'h8);
        rc("gain rst", `DSSB_REG_MON_GAIN, 32'h64);
        rc("rate rst", `DSSB_REG_MON_RATE, 32'h5DC);
        rc("unmapped", 8'hFC, 32'h0);
        $display("test registers done");
        wr(`DSSB_REG_REF_FREQ, 32'h100);
        wr(`DSSB_REG_START_FREQ, 32'h40);
        wr(`DSSB_REG_START_HOLD, 32'h3);
        wr(`DSSB_REG_RAMP_STEP, 32'h10);
        wr(`DSSB_REG_BRK_FREQ, 32'h32);
        wr(`DSSB_REG_BRK_LEVEL, 32'h50);
        wr(`DSSB_REG_BRK_TIME, 32'h2);
        wr(`DSSB_REG_BRK_RESP, 32'h1);
        req <= 3'h1;
        wt(0, 1, 100, n);
        chk("start freq", 16'h40, out_freq_o);
        wt(4, 0, 200, n);
        chk("start hold", 1, n >= 40 && n <= 80);
        wt(0, 1, 20, n);
        req <= 3'h0;
        wt(1, 1, 3000, n);
        @(posedge clk_sys_i);
        #1 chk("quick current", 7'h50, brake_current_o);
        wt(1, 0, 200, n);
        chk("brake time", 1, n >= 20 && n <= 60);
        wr(`DSSB_REG_BRK_TIME, 32'h0);
        req <= 3'h1;
        wt(0, 1, 100, n);
        req <= 3'h0;
        wt(0, 0, 3000, n);
        hold(1, 0, 200, "zero time brake");
        wr(`DSSB_REG_BRK_RESP, 32'h0);
        req <= 3'h2;
        wt(1, 1, 10, n);
        hold(1, 1, 200, "input brake");
        chk("slow current", 1, brake_current_o >= 9 && brake_current_o <= 11);
        req <= 3'h0;
        wt(1, 0, 10, n);
        $display("test sequencer done");
        wr(`DSSB_REG_TONE, 32'h5);
        wr(`DSSB_REG_CARRIER, 32'h1C);
        rc("carrier 1C", `DSSB_REG_CARRIER, 32'h1C);
        chk("tone on", 4'h5, tone_o);
        wr(`DSSB_REG_CARRIER, 32'h1D);
        rc("carrier 1D", `DSSB_REG_CARRIER, 32'h1D);
        chk("tone off", 4'h0, tone_o);
        wr(`DSSB_REG_CARRIER, 32'h28);
        per(2, a, b);
        chk("carrier", 2000, a + b);
        req <= 3'h4;
        per(2, a, b);
        chk("hot carrier", 4000, a + b);
        wr(`DSSB_REG_CAR_RED, 32'h1);
        per(2, a, b);
        chk("no reduce", 2000, a + b);
        $display("test carrier done");
        wr(`DSSB_REG_MON_FORM, 32'h2);
        wr(`DSSB_REG_MON_ITEM, 32'h3);
        wr(`DSSB_REG_MON_RATE, 32'h1770);
        per(3, a, b);
        chk("duty", 1, a - b <= 2 && b - a <= 2);
        chk("pulse rate", 1, a + b >= 3300 && a + b <= 3370);
        chk("pwm in pulse", 0, mon_pwm_o);
        wr(`DSSB_REG_MON_FORM, 32'h0);
        hold(5, 1, 50, "full gain");
        wr(`DSSB_REG_MON_GAIN, 32'h0);
        hold(5, 0, 500, "zero gain");
        chk("pulse in volt", 0, mon_pulse_o);
        $display("test monitor done");
        give_verdict;
    end
endmodule
